// *** verilog/adc_port_map.svh ***
// Purpose: Offsets, field positions, reset values and counts for the dual converter port.
// Assumes: Included by bare name from every design file that needs a constant.
// Notes:   Definitions only.
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// ********************************
// Mode control register addresses
// ********************************
`define ADDR_RESET       7'h00
`define ADDR_FORMAT      7'h01
`define ADDR_OUTPUT      7'h02
`define ADDR_SERIAL      7'h03
`define REG_COUNT        4

// ********************************
// Field positions
// ********************************
`define RESET_BIT        7
`define FMT_TWOS_BIT     0
`define FMT_PD_BIT       1
`define OUT_CUR_MSB      2
`define OUT_CUR_LSB      0
`define OUT_TERM_BIT     3
`define SER_ONE_LANE_BIT 0
`define SER_MODE_MSB     2
`define SER_MODE_LSB     1

// ********************************
// Reset values and drive current codes
// ********************************
`define RESET_RST        8'h00
`define FORMAT_RST       8'h00
`define OUTPUT_RST       8'h00
`define SERIAL_RST       8'h00
`define CUR_3P5MA        3'h0
`define CUR_1P75MA       3'h7

// ********************************
// Serial transfer and data path counts
// ********************************
`define SPI_XFER_BITS    5'h10
`define SPI_ADDR_BITS    5'h08
`define SAMPLE_W         14
`define PAYLOAD_W        31
`define FIFO_DEPTH       4
`define SYNC_W           7

`endif

// *** verilog/adc_port_pkg.sv ***
// Purpose: Types shared by the dual converter port design.
// Assumes: Nothing beyond the map header.
// Notes:   Serialization codes match the serial mode register field.
package adc_port_pkg;

    typedef enum logic [1:0] {
        SER_16 = 2'h0,
        SER_14 = 2'h1,
        SER_12 = 2'h2
    } ser_mode_t;

    typedef enum logic [2:0] {
        SPI_IDLE  = 3'h1,
        SPI_SHIFT = 3'h2,
        SPI_DONE  = 3'h4
    } spi_state_t;

endpackage

// *** verilog/sample_fifo.sv ***
// Purpose: Small synchronous FIFO for converted sample words.
// Assumes: Both sides on one clock; clock_en low freezes it.
// Notes:   Full and empty are exact; in_ready low is back-pressure.
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 31,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             clock_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clock) begin
        if (clock_en && push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (clock_en) begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule // sample_fifo

// *** verilog/lane_serializer.sv ***
// Purpose: Link-side serializer for both channels, lane outputs, frame marker and bit clock.
// Assumes: bit_clock runs free; payload is stable while req_toggle differs from ack_toggle.
// Notes:   One bit per lane per rising bit_clock edge; the forwarded clock toggles on each rising edge.
`timescale 1ns/100ps
`include "adc_port_map.svh"
module lane_serializer
    import adc_port_pkg::*;
(
    input  wire logic                  bit_clock,
    input  wire logic                  rstn,
    input  wire logic                  power_down,
    input  wire logic                  req_toggle,
    input  wire logic [`PAYLOAD_W-1:0] payload,
    output logic                       ack_toggle,
    output logic                       ch1_lane_a,
    output logic                       ch1_lane_b,
    output logic                       ch2_lane_a,
    output logic                       ch2_lane_b,
    output logic                       frame_start_marker,
    output logic                       forwarded_bit_clock
);

    logic        rst_s1_r, rst_s2_r, req_s1_r, req_s2_r, pd_s1_r, pd_s2_r;
    logic [`PAYLOAD_W-1:0] word_r;
    logic [`PAYLOAD_W-1:0] word_nxt;
    logic [31:0] pack1, pack2;
    logic [3:0]  slot_r;
    logic [3:0]  last_slot;
    logic        pair_r;
    logic        halved;
    logic        marker_nxt;
    logic [15:0] sh1a_r, sh1b_r, sh2a_r, sh2b_r;
    logic        pending;

    // Each lane word: two lanes split odd/even bits, one lane keeps the order.
    function automatic logic [31:0] pack(input logic [13:0] d, input logic one_lane);
        logic [15:0] w, a, b;
        w = {d, 2'b00};
        a = '0;
        b = '0;
        for (int k = 0; k < 8; k++) begin
            a[15-k] = w[15-2*k];
            b[15-k] = w[14-2*k];
        end
        return one_lane ? {w, 16'h0000} : {a, b};
    endfunction

    always_ff @(posedge bit_clock) begin
        rst_s1_r <= rstn;
        rst_s2_r <= rst_s1_r;
        req_s1_r <= req_toggle;
        req_s2_r <= req_s1_r;
        pd_s1_r  <= power_down;
        pd_s2_r  <= pd_s1_r;
    end

    assign pending  = (req_s2_r != ack_toggle);
    assign word_nxt = pending ? payload : word_r;
    assign halved   = !word_r[30] && (ser_mode_t'(word_r[29:28]) == SER_14);

    always_comb begin
        case (ser_mode_t'(word_r[29:28]))
            SER_14:  last_slot = word_r[30] ? 4'hD : 4'h6;
            SER_12:  last_slot = word_r[30] ? 4'hB : 4'h5;
            default: last_slot = word_r[30] ? 4'hF : 4'h7;
        endcase
        if (halved) begin
            marker_nxt = !pair_r;
        end else begin
            marker_nxt = ({1'b0, slot_r} < (({1'b0, last_slot} + 5'h01) >> 1));
        end
    end

    assign pack1 = pack(word_nxt[27:14], word_nxt[30]);
    assign pack2 = pack(word_nxt[13:0], word_nxt[30]);

    always_ff @(posedge bit_clock) begin
        if (!rst_s2_r) begin
            slot_r     <= '0;
            pair_r     <= 1'b0;
            ack_toggle <= 1'b0;
            word_r     <= '0;
            sh1a_r     <= '0;
            sh1b_r     <= '0;
            sh2a_r     <= '0;
            sh2b_r     <= '0;
        end else if (slot_r >= last_slot) begin
            slot_r <= '0;
            pair_r <= halved ? !pair_r : 1'b0;
            word_r <= word_nxt;
            sh1a_r <= pack1[31:16];
            sh1b_r <= pack1[15:0];
            sh2a_r <= pack2[31:16];
            sh2b_r <= pack2[15:0];
            if (pending) begin
                ack_toggle <= req_s2_r;
            end
        end else begin
            slot_r <= slot_r + 4'h1;
            sh1a_r <= {sh1a_r[14:0], 1'b0};
            sh1b_r <= {sh1b_r[14:0], 1'b0};
            sh2a_r <= {sh2a_r[14:0], 1'b0};
            sh2b_r <= {sh2b_r[14:0], 1'b0};
        end
    end

    // Outputs lag the slot counter by one edge, marker and data alike.
    always_ff @(posedge bit_clock) begin
        if (!rst_s2_r || pd_s2_r) begin
            ch1_lane_a          <= 1'b0;
            ch1_lane_b          <= 1'b0;
            ch2_lane_a          <= 1'b0;
            ch2_lane_b          <= 1'b0;
            frame_start_marker  <= 1'b0;
            forwarded_bit_clock <= 1'b0;
        end else begin
            ch1_lane_a          <= sh1a_r[15];
            ch1_lane_b          <= sh1b_r[15];
            ch2_lane_a          <= sh2a_r[15];
            ch2_lane_b          <= sh2b_r[15];
            frame_start_marker  <= marker_nxt;
            forwarded_bit_clock <= !forwarded_bit_clock;
        end
    end
endmodule // lane_serializer

// *** verilog/dual_adc_mode_port.sv ***
// Purpose: Mode port, encode capture and output path of a two-channel converter.
// Assumes: clock at 100 MHz; serial pins are slow enough to be sampled after synchronising.
// Notes:   Serial mode holds a small register file; parallel mode decodes the four straps.
`timescale 1ns/100ps
`include "adc_port_map.svh"

// Behaviour
// - Conversion starts on encode rising edge
// - Serial mode: clock accepted only with select low
// - Serial input sampled on clock rising edge
// - Readback driven open-drain, changes on falling edge
// - Parallel: select pin chooses one or two lanes
// - Parallel: clock pin chooses drive current
// - Parallel: data input pin powers down
// - Parallel: output pin enables internal termination
// - One-lane mode leaves second lanes unused
// - Two bits per channel per clock edge, or one
// - Both channels captured at same encode edge
// - Parallel straps control only reduced mode set
// - Two-lane fourteen-bit marker period doubled
// - Other modes marker runs at sample rate
module dual_adc_mode_port
    import adc_port_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 clock_en,
    input  wire logic                 bit_clock,
    input  wire logic                 programming_mode_select,
    input  wire logic                 cs_n,
    input  wire logic                 sck,
    input  wire logic                 sdi,
    input  wire logic                 sdo_in,
    output logic                      sdo_out,
    output logic                      sdo_oe,
    input  wire logic                 encode_clock_pos,
    input  wire logic                 encode_clock_neg,
    output logic                      conversion_start,
    input  wire logic [`SAMPLE_W-1:0] ch1_core_data,
    input  wire logic [`SAMPLE_W-1:0] ch2_core_data,
    output logic                      power_down,
    output logic                      internal_termination_en,
    output logic [2:0]                drive_current_code,
    output logic                      one_lane_mode,
    output logic [1:0]                serialization_mode,
    output logic                      sample_dropped,
    output logic                      ch1_lane_a,
    output logic                      ch1_lane_b,
    output logic                      ch2_lane_a,
    output logic                      ch2_lane_b,
    output logic                      frame_start_marker,
    output logic                      forwarded_bit_clock
);

    // ********************************
    // Pin synchronisers
    // ********************************
    localparam logic [`SYNC_W-1:0] SYNC_INIT = 7'h02;

    logic [`SYNC_W-1:0] pin_raw;
    logic [`SYNC_W-1:0] pin_s1_r;
    logic [`SYNC_W-1:0] pin_s2_r;
    logic               par_mode, cs_s, sck_s, sdi_s, sdo_s, enc_p_s, enc_n_s;

    assign pin_raw = {encode_clock_neg, encode_clock_pos, sdo_in, sdi, sck, cs_n,
                      programming_mode_select};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    pin_s1_r[gi] <= SYNC_INIT[gi];
                    pin_s2_r[gi] <= SYNC_INIT[gi];
                end else if (clock_en) begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                end
            end
        end
    endgenerate

    assign par_mode = pin_s2_r[0];
    assign cs_s     = pin_s2_r[1];
    assign sck_s    = pin_s2_r[2];
    assign sdi_s    = pin_s2_r[3];
    assign sdo_s    = pin_s2_r[4];
    assign enc_p_s  = pin_s2_r[5];
    assign enc_n_s  = pin_s2_r[6];

    // ********************************
    // Serial mode port
    // ********************************
    logic [7:0]  regs_r [`REG_COUNT];
    spi_state_t  spi_state_r;
    spi_state_t  spi_state_nxt;
    logic [4:0]  bit_cnt_r;
    logic [15:0] spi_sh_r;
    logic [7:0]  rd_sh_r;
    logic        sck_prev_r;
    logic        sck_rise, sck_fall, spi_active, read_r;
    logic [15:0] word_in;
    logic        wr_strobe;
    logic [6:0]  addr_in;

    // Select high or parallel mode keeps the engine idle.
    assign spi_active = !par_mode && !cs_s;
    assign sck_rise   = spi_active && sck_s && !sck_prev_r;
    assign sck_fall   = spi_active && !sck_s && sck_prev_r;
    assign word_in    = {spi_sh_r[14:0], sdi_s};
    assign addr_in    = word_in[6:0];
    assign wr_strobe  = (spi_state_r == SPI_SHIFT) && sck_rise
                        && (bit_cnt_r == `SPI_XFER_BITS - 5'h01) && !word_in[15];

    always_comb begin
        spi_state_nxt = spi_state_r;
        case (spi_state_r)
            SPI_IDLE: begin
                if (spi_active) begin
                    spi_state_nxt = SPI_SHIFT;
                end
            end
            SPI_SHIFT: begin
                if (!spi_active) begin
                    spi_state_nxt = SPI_IDLE;
                end else if (sck_rise && bit_cnt_r == `SPI_XFER_BITS - 5'h01) begin
                    spi_state_nxt = SPI_DONE;
                end
            end
            SPI_DONE: begin
                if (!spi_active) begin
                    spi_state_nxt = SPI_IDLE;
                end
            end
            default: spi_state_nxt = SPI_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            spi_state_r <= SPI_IDLE;
            sck_prev_r  <= 1'b0;
            bit_cnt_r   <= '0;
            spi_sh_r    <= '0;
        end else if (clock_en) begin
            spi_state_r <= spi_state_nxt;
            sck_prev_r  <= sck_s;
            if (spi_state_r != SPI_SHIFT) begin
                bit_cnt_r <= '0;
            end else if (sck_rise) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
                spi_sh_r  <= word_in;
            end
        end
    end

    // Readback loads after the eighth bit; the read flag keeps writes off the line.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_sh_r <= 8'hFF;
            sdo_oe  <= 1'b0;
            read_r  <= 1'b0;
        end else if (clock_en) begin
            if (!spi_active) begin
                rd_sh_r <= 8'hFF;
                sdo_oe  <= 1'b0;
                read_r  <= 1'b0;
            end else if (spi_state_r == SPI_SHIFT && sck_rise
                         && bit_cnt_r == `SPI_ADDR_BITS - 5'h01) begin
                rd_sh_r <= (word_in[7] && addr_in < `REG_COUNT) ? regs_r[addr_in[1:0]] : 8'h00;
                read_r  <= word_in[7];
            end else if (sck_fall && read_r && bit_cnt_r >= `SPI_ADDR_BITS
                         && spi_state_r == SPI_SHIFT) begin
                sdo_oe  <= !rd_sh_r[7];
                rd_sh_r <= {rd_sh_r[6:0], 1'b1};
            end else if (sck_fall) begin
                sdo_oe  <= 1'b0;
            end
        end
    end

    assign sdo_out = 1'b0;

    // A write of the reset bit restores every register and itself reads back clear.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            regs_r[0] <= `RESET_RST;
            regs_r[1] <= `FORMAT_RST;
            regs_r[2] <= `OUTPUT_RST;
            regs_r[3] <= `SERIAL_RST;
        end else if (clock_en && wr_strobe) begin
            if (word_in[14:8] == `ADDR_RESET && word_in[`RESET_BIT]) begin
                regs_r[0] <= `RESET_RST;
                regs_r[1] <= `FORMAT_RST;
                regs_r[2] <= `OUTPUT_RST;
                regs_r[3] <= `SERIAL_RST;
            end else if (word_in[14:8] < `REG_COUNT && word_in[14:8] != `ADDR_RESET) begin
                regs_r[word_in[9:8]] <= word_in[7:0];
            end
        end
    end

    // ********************************
    // Effective operating mode
    // ********************************
    logic twos_r;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            power_down              <= 1'b0;
            internal_termination_en <= 1'b0;
            drive_current_code      <= `CUR_3P5MA;
            one_lane_mode           <= 1'b0;
            serialization_mode      <= SER_16;
            twos_r                  <= 1'b0;
        end else if (clock_en) begin
            if (par_mode) begin
                one_lane_mode           <= cs_s;
                drive_current_code      <= sck_s ? `CUR_1P75MA : `CUR_3P5MA;
                power_down              <= sdi_s;
                internal_termination_en <= sdo_s;
                serialization_mode      <= SER_16;
                twos_r                  <= 1'b0;
            end else begin
                power_down              <= regs_r[1][`FMT_PD_BIT];
                twos_r                  <= regs_r[1][`FMT_TWOS_BIT];
                drive_current_code      <= regs_r[2][`OUT_CUR_MSB:`OUT_CUR_LSB];
                internal_termination_en <= regs_r[2][`OUT_TERM_BIT];
                one_lane_mode           <= regs_r[3][`SER_ONE_LANE_BIT];
                serialization_mode      <= (regs_r[3][`SER_MODE_MSB:`SER_MODE_LSB] == 2'h3)
                                           ? SER_16 : regs_r[3][`SER_MODE_MSB:`SER_MODE_LSB];
            end
        end
    end

    // ********************************
    // Encode capture and sample buffering
    // ********************************
    logic                  enc_level, enc_prev_r;
    logic [`PAYLOAD_W-1:0] cap_word_r;
    logic                  cap_valid_r;
    logic                  fifo_in_ready;
    logic [`PAYLOAD_W-1:0] fifo_out_data;
    logic                  fifo_out_valid;
    logic                  hs_ready;
    logic [`PAYLOAD_W-1:0] payload_r;
    logic                  req_r, ack_s1_r, ack_s2_r, ack_toggle;

    // A grounded complement selects single-ended drive, so both pins give one level.
    assign enc_level = enc_p_s && !enc_n_s;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            enc_prev_r       <= 1'b0;
            conversion_start <= 1'b0;
            cap_valid_r      <= 1'b0;
            cap_word_r       <= '0;
            sample_dropped   <= 1'b0;
        end else if (clock_en) begin
            enc_prev_r       <= enc_level;
            conversion_start <= enc_level && !enc_prev_r && !power_down;
            sample_dropped   <= cap_valid_r && !fifo_in_ready;
            cap_valid_r      <= enc_level && !enc_prev_r && !power_down;
            if (enc_level && !enc_prev_r) begin
                cap_word_r <= {one_lane_mode, serialization_mode,
                               ch1_core_data ^ {twos_r, 13'h0000},
                               ch2_core_data ^ {twos_r, 13'h0000}};
            end
        end
    end

    sample_fifo #(
        .WIDTH (`PAYLOAD_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .clock_en  (clock_en),
        .in_data   (cap_word_r),
        .in_valid  (cap_valid_r),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (hs_ready)
    );

    // Toggle handshake: the payload holds still until the link side acknowledges it.
    assign hs_ready = (req_r == ack_s2_r);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            req_r     <= 1'b0;
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
            payload_r <= '0;
        end else if (clock_en) begin
            ack_s1_r <= ack_toggle;
            ack_s2_r <= ack_s1_r;
            if (fifo_out_valid && hs_ready) begin
                payload_r <= fifo_out_data;
                req_r     <= !req_r;
            end
        end
    end

    // ********************************
    // Link side
    // ********************************
    lane_serializer u_ser (
        .bit_clock           (bit_clock),
        .rstn                (rstn),
        .power_down          (power_down),
        .req_toggle          (req_r),
        .payload             (payload_r),
        .ack_toggle          (ack_toggle),
        .ch1_lane_a          (ch1_lane_a),
        .ch1_lane_b          (ch1_lane_b),
        .ch2_lane_a          (ch2_lane_a),
        .ch2_lane_b          (ch2_lane_b),
        .frame_start_marker  (frame_start_marker),
        .forwarded_bit_clock (forwarded_bit_clock)
    );
endmodule // dual_adc_mode_port

// *** test/mode_port_asserts.sv ***
// Purpose: Concurrent checks on the mode port pins and decoded controls.
// Assumes: Pins are synchronised inside, so strap checks wait eight cycles.
// Notes:   Bound into every instance of the mode port.
`timescale 1ns/100ps
module mode_port_asserts (
    input wire logic       clock, rstn, programming_mode_select, cs_n, sck, sdi, sdo_in,
    input wire logic       sdo_oe, encode_clock_pos, encode_clock_neg, conversion_start,
    input wire logic       power_down, internal_termination_en, one_lane_mode,
    input wire logic       ch1_lane_b, ch2_lane_b,
    input wire logic [2:0] drive_current_code,
    input wire logic [1:0] serialization_mode
);
    logic [7:0] lone_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Counting lets a frame already in flight finish before lane b must be quiet.
    always_ff @(posedge clock)
        if (!rstn || !one_lane_mode) lone_r <= 8'h00;
        else if (lone_r != 8'hFF) lone_r <= lone_r + 8'h01;
    sequence straps_held;
        $stable({programming_mode_select, cs_n, sck, sdi, sdo_in})[*8] ##0 programming_mode_select;
    endsequence
    lane_strap_a: assert property (
        straps_held |-> one_lane_mode == cs_n) else $error("lane strap ignored");
    current_strap_a: assert property (
        straps_held |-> drive_current_code == (sck ? 3'h7 : 3'h0)) else $error("current strap");
    power_strap_a: assert property (
        straps_held |-> power_down == sdi) else $error("power strap ignored");
    term_strap_a: assert property (
        straps_held |-> internal_termination_en == sdo_in) else $error("term strap ignored");
    reduced_modes_a: assert property (
        straps_held |-> serialization_mode == 2'h0) else $error("strap mode not fixed");
    encode_start_a: assert property (
        $rose(encode_clock_pos && !encode_clock_neg) && !power_down |-> ##[2:4] conversion_start)
        else $error("no conversion start");
    pd_no_start_a: assert property (
        power_down && $past(power_down, 4) |-> !conversion_start) else $error("start in power down");
    cs_high_hold_a: assert property (
        (!programming_mode_select && cs_n)[*8] |-> $stable({one_lane_mode, serialization_mode,
        drive_current_code, internal_termination_en, power_down})) else $error("mode changed");
    sdo_release_a: assert property (
        (programming_mode_select || cs_n)[*6] |-> !sdo_oe) else $error("serial output driven");
    lane_b_idle_a: assert property (
        lone_r == 8'hFF |-> !ch1_lane_b && !ch2_lane_b) else $error("lane b active");
endmodule // mode_port_asserts
bind dual_adc_mode_port mode_port_asserts u_chk (.*);

// *** test/lane_receiver.sv ***
// Purpose: Receiver capturing lane a of both channels at both forwarded clock edges.
// Assumes: Word capture is meaningful in one-lane sixteen-bit framing.
// Notes:   Samples an eighth of a forwarded clock period late, since data and clock leave together.
`timescale 1ns/100ps
module lane_receiver (
    input  wire logic        forwarded_bit_clock,
    input  wire logic        ch1_lane_a,
    input  wire logic        ch2_lane_a,
    input  wire logic        frame_start_marker,
    output logic      [15:0] word1_r,
    output logic      [15:0] word2_r,
    output logic      [15:0] period_r
);
    logic [15:0] sh1 = '0, sh2 = '0, cnt = '0;
    logic        mk = 1'b0;
    always @(forwarded_bit_clock) begin
        #12;
        if (frame_start_marker && !mk) begin
            word1_r = sh1;
            word2_r = sh2;
            period_r = cnt;
            cnt = 16'h0;
        end
        sh1 = {sh1[14:0], ch1_lane_a};
        sh2 = {sh2[14:0], ch2_lane_a};
        cnt = cnt + 16'h1;
        mk = frame_start_marker;
    end
endmodule // lane_receiver

// *** test/tb.sv ***
// Purpose: Self-checking bench for the dual converter mode port.
// Assumes: Pins change on the falling clock edge.
// Notes:   One sck period is 100 ns, slow enough for readback.
`timescale 1ns/100ps
module tb;
    logic        clock = 1'b0, bit_clock = 1'b0, rstn = 1'b0, clock_en = 1'b1, term = 1'b0;
    logic        programming_mode_select = 1'b0, cs_n = 1'b1, sck = 1'b0, sdi = 1'b0;
    logic        encode_clock_pos = 1'b0, encode_clock_neg = 1'b0;
    logic [13:0] ch1_core_data = 14'h1A5C, ch2_core_data = 14'h0E31;
    logic        sdo_out, sdo_oe, conversion_start, power_down, internal_termination_en;
    logic        one_lane_mode, sample_dropped, ch1_lane_a, ch1_lane_b, ch2_lane_a, ch2_lane_b;
    logic        frame_start_marker, forwarded_bit_clock;
    logic [2:0]  drive_current_code;
    logic [1:0]  serialization_mode;
    logic [15:0] word1_r, word2_r, period_r;
    logic [7:0]  rd;
    int          errors = 0, total_checks = 0, drops = 0;
    int          per [6] = '{8, 16, 14, 14, 6, 12};
    // Pulled-up open-drain line in serial mode, termination strap in parallel mode.
    wire         sdo_in = programming_mode_select ? term : (sdo_oe ? sdo_out : 1'b1);
    dual_adc_mode_port u_dut (.*);
    lane_receiver      u_rx (.*);
    initial forever #5 clock = ~clock;
    initial begin
        #3;
        forever begin
            bit_clock = ~bit_clock;
            #24;
        end
    end
    always @(negedge clock) if (sample_dropped === 1'b1) drops++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic spi(input logic [15:0] w, input logic sel);
        cs_n = !sel;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            repeat (5) @(negedge clock);
            sck = 1'b1;
            repeat (5) @(negedge clock);
            if (i < 8) rd = {rd[6:0], sdo_in};
            sck = 1'b0;
        end
        repeat (5) @(negedge clock);
        cs_n = 1'b1;
        repeat (10) @(negedge clock);
    endtask
    task automatic enc(input int n, input int gap);
        repeat (n) begin
            encode_clock_pos = 1'b1;
            repeat (gap) @(negedge clock);
            encode_clock_pos = 1'b0;
            repeat (gap) @(negedge clock);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        repeat (5) @(negedge clock);
        spi(16'h0302, 1'b1);
        chk(serialization_mode, 2'h1);
        spi(16'h8300, 1'b1);
        chk(rd, 8'h02);
        spi(16'h0300, 1'b0);
        chk(serialization_mode, 2'h1);
        for (int m = 0; m < 6; m++) begin
            spi({8'h03, 8'(m)}, 1'b1);
            enc(2, 20);
            repeat (300) @(negedge clock);
            chk(period_r, 16'(per[m]));
            if (m == 1) chk(word1_r, {ch1_core_data, 2'h0});
            if (m == 1) chk(word2_r, {ch2_core_data, 2'h0});
        end
        // A fast burst overflows the four-word buffer.
        enc(12, 1);
        repeat (300) @(negedge clock);
        chk(16'(drops > 0), 16'h1);
        spi(16'h0102, 1'b1);
        chk(power_down, 1'b1);
        enc(2, 20);
        programming_mode_select = 1'b1;
        for (int p = 0; p < 2; p++) begin
            {cs_n, sck, sdi, term} = {4{p[0]}};
            repeat (12) @(negedge clock);
            chk({one_lane_mode, drive_current_code}, {4{p[0]}});
            chk({internal_termination_en, power_down}, {2{p[0]}});
            chk(serialization_mode, 2'h0);
        end
        final_report();
    end
endmodule // tb
